/* swk_axil.sv */
// AXI4-Lite slave that turns bus transfers into register strobes.
`timescale 1ns/1ps
`include "swk_regs.svh"
module swk_axil
   import swk_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   input  wire logic        i_rready,
   output      swk_axi_type o_st,
   swk_regbus_if.bridge     bus
);
   swk_axi_type r_reg;
   swk_axi_type r_next;
   assign o_st = r_reg;
   // Address and data are caught apart; the write lands once both are in.
   always_comb
   begin
      r_next = r_reg;
      bus.wr_en = r_reg.aw_got && r_reg.w_got && !r_reg.bvalid;
      bus.wr_addr = r_reg.waddr;
      bus.wr_data = r_reg.wdata;
      bus.wr_strb = r_reg.wstrb;
      bus.rd_en = i_arvalid && r_reg.arready;
      bus.rd_addr = i_araddr;
      if (i_awvalid && r_reg.awready)
      begin
         r_next.aw_got = 1'b1;
         r_next.waddr = i_awaddr;
      end
      if (i_wvalid && r_reg.wready)
      begin
         r_next.w_got = 1'b1;
         r_next.wdata = i_wdata;
         r_next.wstrb = i_wstrb;
      end
      if (bus.wr_en)
      begin
         r_next.aw_got = 1'b0;
         r_next.w_got = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = bus.wr_err ? `SWK_RESP_ERR : `SWK_RESP_OK;
      end
      else if (r_reg.bvalid && i_bready)
         r_next.bvalid = 1'b0;
      // Read data is caught before any clear-on-read takes effect.
      if (bus.rd_en)
      begin
         r_next.rvalid = 1'b1;
         r_next.rdata = bus.rd_data;
         r_next.rresp = bus.rd_err ? `SWK_RESP_ERR : `SWK_RESP_OK;
      end
      else if (r_reg.rvalid && i_rready)
         r_next.rvalid = 1'b0;
      r_next.awready = !r_next.aw_got && !r_next.bvalid;
      r_next.wready = !r_next.w_got && !r_next.bvalid;
      r_next.arready = !r_next.rvalid;
      if (i_reset)
         r_next = '0;
   end
   // State register.
   always_ff @(posedge i_clk)
   begin
      r_reg <= r_next;
   end
endmodule

/* swk_pkg.sv */
// Types and shared helper functions of the standby wake block.
package swk_pkg;
   // Wake edge-select encoding; 101 to 111 are not to be programmed.
   typedef enum logic [2:0]
   {
      SEL_LOW  = 3'h0,
      SEL_HIGH = 3'h1,
      SEL_FALL = 3'h2,
      SEL_RISE = 3'h3,
      SEL_BOTH = 3'h4
   } swk_sel_type;
   // State of the edge detector.
   typedef struct packed
   {
      logic       prev;
      logic       prev_ok;
      logic [1:0] seen;
      logic       wake;
   } swk_wake_type;
   // State of the bus slave.
   typedef struct packed
   {
      logic        aw_got;
      logic        w_got;
      logic [7:0]  waddr;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } swk_axi_type;
   // State of the register file.
   typedef struct packed
   {
      logic [31:0] wake_ctl;
      logic [1:0]  nmi;
      logic [4:0]  rflags;
      logic [2:0]  stat;
      logic [2:0]  mask;
      logic [12:0] clr_pulse;
      logic        wake_prev;
      logic        irq;
   } swk_top_type;
   // Merges written byte lanes into an old word.
   function automatic logic [31:0] apply_strb(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      return res;
   endfunction
   // True for an address that holds a register.
   function automatic logic addr_known(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= 8'h14;
   endfunction
endpackage

/* swk_regbus_if.sv */
// Internal register strobe bus between the bus slave and the registers.
`timescale 1ns/1ps
interface swk_regbus_if;
   logic        wr_en;   // One-cycle write strobe.
   logic [7:0]  wr_addr; // Write byte address.
   logic [31:0] wr_data; // Write data.
   logic [3:0]  wr_strb; // Write byte lanes.
   logic        wr_err;  // Write address unmapped.
   logic        rd_en;   // One-cycle read strobe.
   logic [7:0]  rd_addr; // Read byte address.
   logic [31:0] rd_data; // Read data, valid with rd_en.
   logic        rd_err;  // Read address unmapped.
   modport bridge (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      input wr_err, rd_data, rd_err);
   modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
      output wr_err, rd_data, rd_err);
endinterface

/* swk_regs.svh */
// Register offsets, field positions, reset values and codes of the block.
`ifndef SWK_REGS_SVH
`define SWK_REGS_SVH
`define SWK_OFS_WAKE     8'h00
`define SWK_OFS_CLR      8'h04
`define SWK_OFS_NMI      8'h08
`define SWK_OFS_RST      8'h0c
`define SWK_OFS_STAT     8'h10
`define SWK_OFS_MASK     8'h14
`define SWK_WAKE_RW_MASK 32'h7070_7071
`define SWK_WAKE_RESET   32'h2020_2020
`define SWK_SEL_LSB      4
`define SWK_SEEN_LSB     2
`define SWK_CODE_CEC_TX  5'h0c
`define SWK_CODE_LAST    5'h0c
`define SWK_RST_POR      5'h01
`define SWK_RESP_OK      2'h0
`define SWK_RESP_ERR     2'h2
`endif

/* swk_top.sv */
// Standby wake setup, request clear, NMI source and reset cause registers.
// Operation
// - Report triggering edge in two-bit field.
// - Edge field meaningful only in both-edges mode.
// - Request clear also zeroes the edge field.
// - Clear code clears exactly one pending request.
// - Watchdog NMI sets source flag bit 0.
// - Pin NMI sets source flag bit 1.
// - Reading NMI flags returns then clears them.
// - CPU system reset request sets bit 4.
// - Watchdog reset sets reset-cause bit 2.
// - Pin reset sets reset-cause bit 1.
// - Power-on reset sets reset-cause bit 0.
// - Reset-cause flags persist until software writes zero; here a power-on also replaces them.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`include "swk_regs.svh"
module swk_top
   import swk_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESET,
   input  wire logic        I_POWER_ON,
   input  wire logic        I_RST_BY_PIN,
   input  wire logic        I_RST_BY_WDT,
   input  wire logic        I_RST_BY_SYSREQ,
   input  wire logic        I_NMI_WDT,
   input  wire logic        I_NMI_PIN,
   input  wire logic        I_CEC_TX_IRQ,
   input  wire logic [7:0]  I_AWADDR,
   input  wire logic        I_AWVALID,
   input  wire logic [31:0] I_WDATA,
   input  wire logic [3:0]  I_WSTRB,
   input  wire logic        I_WVALID,
   input  wire logic        I_BREADY,
   input  wire logic [7:0]  I_ARADDR,
   input  wire logic        I_ARVALID,
   input  wire logic        I_RREADY,
   output      logic        O_AWREADY,
   output      logic        O_WREADY,
   output      logic        O_BVALID,
   output      logic [1:0]  O_BRESP,
   output      logic        O_ARREADY,
   output      logic        O_RVALID,
   output      logic [31:0] O_RDATA,
   output      logic [1:0]  O_RRESP,
   output      logic [12:0] O_PEND_CLR,
   output      logic        O_CEC_TX_WAKE,
   output      logic        O_IRQ
);
   swk_regbus_if bus ();         // Strobes between bus slave and registers.
   swk_axi_type  axi_st;         // Bus slave state, all flip-flops.
   swk_top_type  r_reg;          // Register file state.
   swk_top_type  r_next;         // Next register file state.
   logic [1:0]   edge_seen;      // Detected edge of the CEC-transmit source.
   logic         wake_lvl;       // Pending wake request of that source.
   logic         wr_wake;        // Write strobe decodes.
   logic         wr_clr;
   logic         wr_rst;
   logic         wr_mask;
   logic         rd_nmi;         // Read strobe decodes.
   logic         rd_stat;
   logic [4:0]   clr_code;       // Code written to the clear field.
   logic [4:0]   causes;         // Reset causes seen this cycle.

   // Bus outputs leave straight from the slave's flip-flops.
   assign O_AWREADY = axi_st.awready;
   assign O_WREADY = axi_st.wready;
   assign O_BVALID = axi_st.bvalid;
   assign O_BRESP = axi_st.bresp;
   assign O_ARREADY = axi_st.arready;
   assign O_RVALID = axi_st.rvalid;
   assign O_RDATA = axi_st.rdata;
   assign O_RRESP = axi_st.rresp;
   assign O_PEND_CLR = r_reg.clr_pulse;
   assign O_CEC_TX_WAKE = wake_lvl;
   assign O_IRQ = r_reg.irq;

   // Bus slave; a write lands one edge after its last handshake.
   swk_axil u_axil
   (
      .i_clk     (I_CLK_SYS),
      .i_reset   (I_RESET),
      .i_awaddr  (I_AWADDR),
      .i_awvalid (I_AWVALID),
      .i_wdata   (I_WDATA),
      .i_wstrb   (I_WSTRB),
      .i_wvalid  (I_WVALID),
      .i_bready  (I_BREADY),
      .i_araddr  (I_ARADDR),
      .i_arvalid (I_ARVALID),
      .i_rready  (I_RREADY),
      .o_st      (axi_st),
      .bus       (bus.bridge)
   );

   // Edge detector of the CEC-transmit wake source.
   swk_wake u_wake
   (
      .i_clk    (I_CLK_SYS),
      .i_reset  (I_RESET),
      .i_src    (I_CEC_TX_IRQ),
      .i_sel    (swk_sel_type'(r_reg.wake_ctl[`SWK_SEL_LSB +: 3])),
      .i_enable (r_reg.wake_ctl[0]),
      .i_clear  (r_reg.clr_pulse[12]),
      .o_seen   (edge_seen),
      .o_wake   (wake_lvl)
   );

   // Register file: decode, side effects of access, flags and interrupt.
   always_comb
   begin
      r_next = r_reg;
      wr_wake = bus.wr_en && bus.wr_addr == `SWK_OFS_WAKE;
      wr_clr = bus.wr_en && bus.wr_addr == `SWK_OFS_CLR && bus.wr_strb[0];
      wr_rst = bus.wr_en && bus.wr_addr == `SWK_OFS_RST && bus.wr_strb[0];
      wr_mask = bus.wr_en && bus.wr_addr == `SWK_OFS_MASK;
      rd_nmi = bus.rd_en && bus.rd_addr == `SWK_OFS_NMI;
      rd_stat = bus.rd_en && bus.rd_addr == `SWK_OFS_STAT;
      clr_code = bus.wr_data[4:0];
      causes = {I_RST_BY_SYSREQ, 1'b0, I_RST_BY_WDT, I_RST_BY_PIN, 1'b0};
      bus.wr_err = !addr_known(bus.wr_addr);
      bus.rd_err = !addr_known(bus.rd_addr);

      // Read data; unused bits and the write-only clear field read zero.
      case (bus.rd_addr)
         `SWK_OFS_WAKE:
            bus.rd_data = (r_reg.wake_ctl & `SWK_WAKE_RW_MASK)
               | {28'h0, edge_seen, 2'h0};
         `SWK_OFS_NMI:
            bus.rd_data = {30'h0, r_reg.nmi};
         `SWK_OFS_RST:
            bus.rd_data = {27'h0, r_reg.rflags};
         `SWK_OFS_STAT:
            bus.rd_data = {29'h0, r_reg.stat};
         `SWK_OFS_MASK:
            bus.rd_data = {29'h0, r_reg.mask};
         default:
            bus.rd_data = 32'h0;
      endcase

      // Software owns edge select and enable; other bits in the write mask are plain storage, the rest stay zero.
      // select and enable
      if (wr_wake)
         r_next.wake_ctl = apply_strb(r_reg.wake_ctl, bus.wr_data,
            bus.wr_strb) & `SWK_WAKE_RW_MASK;

      // Clear pulses last one cycle; codes above the last are dropped.
      // one-hot clear decode
      r_next.clr_pulse = 13'h0;
      if (wr_clr && clr_code <= `SWK_CODE_LAST)
         r_next.clr_pulse[clr_code[3:0]] = 1'b1;

      // A source event in the reading cycle survives the clear.
      // clear on read
      if (rd_nmi)
         r_next.nmi = 2'h0;
      r_next.nmi = r_next.nmi | {I_NMI_PIN, I_NMI_WDT};

      // Writing one keeps a flag, zero clears it; causes then OR in.
      // clear by software write or power-on
      if (wr_rst)
         r_next.rflags = r_reg.rflags & bus.wr_data[4:0];
      r_next.rflags = r_next.rflags | causes;
      if (I_POWER_ON)
         r_next.rflags = `SWK_RST_POR | causes;

      // Interrupt status, cleared by its read, gated by the mask.
      r_next.wake_prev = wake_lvl;
      if (rd_stat)
         r_next.stat = 3'h0;
      r_next.stat = r_next.stat
         | {I_NMI_PIN, I_NMI_WDT, wake_lvl && !r_reg.wake_prev};
      if (wr_mask)
         r_next.mask = bus.wr_data[2:0] & {3{bus.wr_strb[0]}};
      r_next.irq = |(r_next.stat & r_next.mask);

      // Reset leaves the reset-cause flags alone so they outlive it.
      if (I_RESET)
      begin
         r_next.wake_ctl = `SWK_WAKE_RESET;
         r_next.nmi = 2'h0;
         r_next.stat = 3'h0;
         r_next.mask = 3'h0;
         r_next.clr_pulse = 13'h0;
         r_next.wake_prev = 1'b0;
         r_next.irq = 1'b0;
      end
   end

   // State register.
   always_ff @(posedge I_CLK_SYS)
   begin
      r_reg <= r_next;
   end

   // Checks, sampled on the system clock; all but the reset-cause, power-on and flag-keep checks are idle under reset.
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (I_RESET);

   // A watchdog NMI is seen in flag bit 0 one edge later.
   property p_nmi_wdt;
      I_NMI_WDT |=> r_reg.nmi[0];
   endproperty
   a_nmi_wdt: assert property (p_nmi_wdt)
      else $error("Watchdog NMI flag not set.");

   // A pin NMI is seen in flag bit 1 one edge later.
   property p_nmi_pin;
      I_NMI_PIN |=> r_reg.nmi[1];
   endproperty
   a_nmi_pin: assert property (p_nmi_pin)
      else $error("Pin NMI flag not set.");

   // A read with no new event empties the flags and returns the old ones.
   property p_nmi_rd;
      rd_nmi && !I_NMI_WDT && !I_NMI_PIN |=> r_reg.nmi == 2'h0
         ##1 O_RDATA[1:0] == $past(r_reg.nmi, 2);
   endproperty
   a_nmi_rd: assert property (p_nmi_rd)
      else $error("NMI flags not returned and cleared.");

   // Each cause lands in its own flag, even while reset is held.
   property p_rst_cause;
      disable iff (1'b0)
      I_RST_BY_SYSREQ |=> r_reg.rflags[4];
   endproperty
   a_rst_cause: assert property (p_rst_cause)
      else $error("System reset request flag not set.");

   property p_rst_wdt;
      disable iff (1'b0)
      I_RST_BY_WDT |=> r_reg.rflags[2];
   endproperty
   a_rst_wdt: assert property (p_rst_wdt)
      else $error("Watchdog reset flag not set.");

   property p_rst_pin;
      disable iff (1'b0)
      I_RST_BY_PIN |=> r_reg.rflags[1];
   endproperty
   a_rst_pin: assert property (p_rst_pin)
      else $error("Pin reset flag not set.");

   property p_por;
      disable iff (1'b0)
      I_POWER_ON |=> r_reg.rflags[0] && r_reg.rflags[3] == 1'b0;
   endproperty
   a_por: assert property (p_por)
      else $error("Power-on flag not set.");

   // Without a write or power-on, no flag ever drops, reset or not.
   property p_rst_keep;
      disable iff (1'b0)
      !wr_rst && !I_POWER_ON |=> ($past(r_reg.rflags) & ~r_reg.rflags) == 5'h0;
   endproperty
   a_rst_keep: assert property (p_rst_keep)
      else $error("Reset flag dropped without a write.");

   // A write of ones keeps every flag; only causes present can add to them.
   property p_wr_one;
      wr_rst && bus.wr_data[4:0] == 5'h1f && !I_POWER_ON
         |=> r_reg.rflags == ($past(r_reg.rflags) | $past(causes));
   endproperty
   a_wr_one: assert property (p_wr_one)
      else $error("Writing one changed a reset flag.");

   // The CEC-transmit clear pulses one line for one cycle, then the edge
   // field is zero unless a fresh edge arrived.
   sequence s_clr_pulse;
      r_reg.clr_pulse == 13'h1000 ##1 r_reg.clr_pulse == 13'h0;
   endsequence
   property p_clr_code;
      wr_clr && clr_code == `SWK_CODE_CEC_TX |=> s_clr_pulse;
   endproperty
   a_clr_code: assert property (p_clr_code)
      else $error("Clear code did not pulse one line.");

   property p_clr_seen;
      r_reg.clr_pulse[12] && $stable(I_CEC_TX_IRQ) |=> edge_seen == 2'h0;
   endproperty
   a_clr_seen: assert property (p_clr_seen)
      else $error("Edge field survived a clear.");

   // Outside both-edges mode the edge field never gains a bit.
   property p_seen_mode;
      r_reg.wake_ctl[6:4] != 3'h4 |=> (edge_seen & ~$past(edge_seen)) == 2'h0;
   endproperty
   a_seen_mode: assert property (p_seen_mode)
      else $error("Edge field changed outside both-edges mode.");

   // In both-edges mode a rising edge shows as bit 0 one edge later.
   property p_seen_rise;
      r_reg.wake_ctl[6:4] == 3'h4 && $rose(I_CEC_TX_IRQ)
         && !r_reg.clr_pulse[12] && !wr_wake |=> edge_seen[0];
   endproperty
   a_seen_rise: assert property (p_seen_rise)
      else $error("Rising edge not reported.");

   // In both-edges mode a falling edge shows as bit 1 one edge later.
   property p_seen_fall;
      r_reg.wake_ctl[6:4] == 3'h4 && $fell(I_CEC_TX_IRQ)
         && !r_reg.clr_pulse[12] && !wr_wake |=> edge_seen[1];
   endproperty
   a_seen_fall: assert property (p_seen_fall)
      else $error("Falling edge not reported.");

   // In rising mode with no fresh edge, the CEC-transmit clear drops its pending request.
   // Level modes are left out, since a held level sets it again.
   property p_clr_wake;
      r_reg.clr_pulse[12] && r_reg.wake_ctl[6:4] == 3'h3
         && $stable(I_CEC_TX_IRQ) |=> !O_CEC_TX_WAKE;
   endproperty
   a_clr_wake: assert property (p_clr_wake)
      else $error("Pending wake request survived its clear.");

   // A zero written with no cause present empties every reset flag.
   property p_rst_zero;
      wr_rst && bus.wr_data[4:0] == 5'h0 && causes == 5'h0 && !I_POWER_ON
         |=> r_reg.rflags == 5'h0;
   endproperty
   a_rst_zero: assert property (p_rst_zero)
      else $error("Writing zero left a reset flag set.");

   // The write-only clear field always reads back as zero.
   property p_clr_rd_zero;
      bus.rd_en && bus.rd_addr == `SWK_OFS_CLR |=> O_RDATA == 32'h0;
   endproperty
   a_clr_rd_zero: assert property (p_clr_rd_zero)
      else $error("Clear field read back nonzero.");

   // An unmasked watchdog NMI raises the interrupt one edge later; a mask
   // written in the same cycle could hide it, so that case is left out.
   property p_irq_wdt;
      I_NMI_WDT && r_reg.mask[1] && !wr_mask |=> O_IRQ;
   endproperty
   a_irq_wdt: assert property (p_irq_wdt)
      else $error("Unmasked watchdog NMI did not raise the interrupt.");
endmodule

/* swk_wake.sv */
// Edge detector and pending flag of the CEC-transmit wake source.
`timescale 1ns/1ps
module swk_wake
   import swk_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset,
   input  wire logic        i_src,
   input  wire swk_sel_type i_sel,
   input  wire logic        i_enable,
   input  wire logic        i_clear,
   output      logic [1:0]  o_seen,
   output      logic        o_wake
);
   swk_wake_type r_reg;
   swk_wake_type r_next;
   logic         rise;
   logic         fall;
   logic         hit;
   assign o_seen = r_reg.seen;
   assign o_wake = r_reg.wake;
   // No edge is claimed before one earlier sample exists.
   always_comb
   begin
      r_next = r_reg;
      rise = r_reg.prev_ok && i_src && !r_reg.prev;
      fall = r_reg.prev_ok && !i_src && r_reg.prev;
      case (i_sel)
         SEL_LOW:  hit = !i_src;
         SEL_HIGH: hit = i_src;
         SEL_FALL: hit = fall;
         SEL_RISE: hit = rise;
         SEL_BOTH: hit = rise || fall;
         default:  hit = 1'b0;
      endcase
      r_next.prev = i_src;
      r_next.prev_ok = 1'b1;
      if (i_clear)
      begin
         r_next.seen = 2'h0;
         r_next.wake = 1'b0;
      end
      // Edges are logged only in both-edges mode; a new edge beats a clear.
      // both-edges only
      if (i_sel == SEL_BOTH)
         r_next.seen = r_next.seen | {fall, rise};
      if (hit && i_enable)
         r_next.wake = 1'b1;
      if (i_reset)
         r_next = '0;
   end
   // State register.
   always_ff @(posedge i_clk)
   begin
      r_reg <= r_next;
   end
endmodule

/* tb.sv */
// Self-checking testbench of the standby wake register block.
`timescale 1ns/1ps
`include "swk_regs.svh"
module tb;
   import swk_pkg::*;
   // One table row: an access and the read-back it should give.
   typedef struct
   {
      logic [7:0]  a;
      logic [31:0] d;
      logic        w;
      logic [31:0] exp;
      logic [1:0]  resp;
   } swk_row_type;
   logic        clk     = 1'b0;  // System clock.
   logic        rst     = 1'b1;  // Synchronous reset.
   logic        por     = 1'b1;  // Power-on indication.
   logic [2:0]  cause   = 3'h0;  // Pin, watchdog, system request causes.
   logic        nmi_wdt = 1'b0;  // Watchdog NMI event.
   logic        nmi_pin = 1'b0;  // Pin NMI event.
   logic        cec     = 1'b0;  // CEC transmit source.
   logic [7:0]  awaddr  = 8'h00; // Write address.
   logic [7:0]  araddr  = 8'h00; // Read address.
   logic [31:0] wdata   = 32'h0; // Write data.
   logic        awvalid = 1'b0;  // Bus master strobes.
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic [3:0]  wstrb   = 4'hf;  // Write byte lanes.
   logic        awready, wready, bvalid, arready, rvalid, irq, wake;
   logic [1:0]  bresp, rresp, resp;
   logic [31:0] rdata, data, exp;
   logic [12:0] pend_clr;
   logic [12:0] pend_acc = 13'h0; // Every clear line seen so far.
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cycles = 0;
   swk_row_type rows [7];
   always #5 clk = ~clk;
   swk_top DUT (.I_CLK_SYS(clk), .I_RESET(rst), .I_POWER_ON(por),
      .I_RST_BY_PIN(cause[0]), .I_RST_BY_WDT(cause[1]),
      .I_RST_BY_SYSREQ(cause[2]), .I_NMI_WDT(nmi_wdt), .I_NMI_PIN(nmi_pin),
      .I_CEC_TX_IRQ(cec), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .I_RREADY(rready),
      .O_AWREADY(awready), .O_WREADY(wready), .O_BVALID(bvalid),
      .O_BRESP(bresp), .O_ARREADY(arready), .O_RVALID(rvalid),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_PEND_CLR(pend_clr),
      .O_CEC_TX_WAKE(wake), .O_IRQ(irq));
   // Collect clear pulses, since each stands for one cycle only; the
   // unknown state before the first reset edge is kept out.
   always @(posedge clk)
      if (!rst)
         pend_acc <= pend_acc | pend_clr;
   // A hang is cut short here and counted as a mismatch.
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk_word(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_resp(input string nm, input logic [1:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, g);
      n_tests++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   // Write: both halves offered together, each dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bready && bvalid)
         begin
            resp = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   // Read: address held until taken, data taken at the rvalid edge.
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever
      begin
         @(posedge clk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rready && rvalid)
         begin
            data = rdata;
            resp = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic do_reset(input logic p, input logic [2:0] c);
      @(posedge clk);
      rst <= 1'b1;
      por <= p;
      cause <= c;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      por <= 1'b0;
      cause <= 3'h0;
   endtask
   task automatic pulse_nmi(input logic pin);
      @(posedge clk);
      if (pin)
         nmi_pin <= 1'b1;
      else
         nmi_wdt <= 1'b1;
      @(posedge clk);
      nmi_pin <= 1'b0;
      nmi_wdt <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task automatic set_cec(input logic v);
      @(posedge clk);
      cec <= v;
      repeat (3) @(posedge clk);
   endtask
   initial
   begin
      rows = '{
         '{8'h00, 32'h4444_4441, 1'b1, 32'h4040_4041, `SWK_RESP_OK},
         '{8'h00, 32'hffff_ff31, 1'b1, 32'h7070_7031, `SWK_RESP_OK},
         '{8'h04, 32'h0000_000c, 1'b1, 32'h0,         `SWK_RESP_OK},
         '{8'h14, 32'hffff_ffff, 1'b1, 32'h7,         `SWK_RESP_OK},
         '{8'h18, 32'h0000_0001, 1'b1, 32'h0,         `SWK_RESP_ERR},
         '{8'h08, 32'h0,         1'b0, 32'h0,         `SWK_RESP_OK},
         '{8'h10, 32'h0,         1'b0, 32'h0,         `SWK_RESP_OK}};
      do_reset(1'b1, 3'h0);
      // power-on flag after the first reset.
      rd(`SWK_OFS_RST);
      exp = 32'h1;
      chk_word("reset cause", exp, data);
      // flags gather over later resets of each cause.
      for (int k = 0; k < 3; k++)
      begin
         do_reset(1'b0, 3'h1 << k);
         exp = exp | ((k == 2) ? 32'h10 : (32'h2 << k));
         rd(`SWK_OFS_RST);
         chk_word("reset cause", exp, data);
      end
      wr(`SWK_OFS_RST, 32'h1f);
      rd(`SWK_OFS_RST);
      chk_word("reset cause ones", exp, data);
      // a zero without byte lane 0 clears nothing.
      wstrb <= 4'he;
      wr(`SWK_OFS_RST, 32'h0);
      rd(`SWK_OFS_RST);
      wstrb <= 4'hf;
      chk_word("reset cause lanes", exp, data);
      wr(`SWK_OFS_RST, 32'h0);
      rd(`SWK_OFS_RST);
      chk_word("reset cause zero", 32'h0, data);
      // each clear code but 5 and 9 to 11 reaches exactly its own line.
      exp = 32'h0;
      for (int c = 0; c <= 12; c++)
      begin
         if (c == 5 || (c > 8 && c < 12))
            continue;
         exp = exp | (32'h1 << c);
         wr(`SWK_OFS_CLR, c);
         repeat (2) @(posedge clk);
         chk_word("clear lines", exp, {19'h0, pend_acc});
      end
      // Ordinary register accesses, an unmapped place among them.
      foreach (rows[i])
      begin
         if (rows[i].w)
         begin
            wr(rows[i].a, rows[i].d);
            chk_resp("write resp", rows[i].resp, resp);
         end
         rd(rows[i].a);
         chk_word("read data", rows[i].exp, data);
         chk_resp("read resp", rows[i].resp, resp);
      end
      // watchdog flag set, masked interrupt stays low.
      wr(`SWK_OFS_MASK, 32'h0);
      pulse_nmi(1'b0);
      chk_bit("irq masked", 1'b0, irq);
      rd(`SWK_OFS_STAT);
      chk_word("status", 32'h2, data);
      rd(`SWK_OFS_NMI);
      chk_word("nmi flags", 32'h1, data);
      rd(`SWK_OFS_NMI);
      chk_word("nmi flags", 32'h0, data);
      wr(`SWK_OFS_MASK, 32'h2);
      pulse_nmi(1'b0);
      chk_bit("irq", 1'b1, irq);
      rd(`SWK_OFS_STAT);
      repeat (2) @(posedge clk);
      chk_bit("irq cleared", 1'b0, irq);
      // pin flag; the watchdog flag of the last pulse is still unread.
      pulse_nmi(1'b1);
      chk_bit("irq other", 1'b0, irq);
      rd(`SWK_OFS_NMI);
      chk_word("nmi flags", 32'h3, data);
      // rising mode wakes, edge field stays zero.
      wr(`SWK_OFS_WAKE, 32'h31);
      set_cec(1'b1);
      chk_bit("wake", 1'b1, wake);
      rd(`SWK_OFS_WAKE);
      chk_word("wake ctl", 32'h31, data);
      set_cec(1'b0);
      wr(`SWK_OFS_CLR, `SWK_CODE_CEC_TX);
      repeat (3) @(posedge clk);
      chk_bit("wake cleared", 1'b0, wake);
      // both-edges mode reports edges, clear zeroes them.
      wr(`SWK_OFS_WAKE, 32'h41);
      set_cec(1'b1);
      rd(`SWK_OFS_WAKE);
      chk_word("edge rise", 32'h45, data);
      set_cec(1'b0);
      rd(`SWK_OFS_WAKE);
      chk_word("edge both", 32'h4d, data);
      wr(`SWK_OFS_CLR, `SWK_CODE_CEC_TX);
      repeat (2) @(posedge clk);
      rd(`SWK_OFS_WAKE);
      chk_word("edge cleared", 32'h41, data);
      // low-level mode sets the request while the source is low.
      wr(`SWK_OFS_WAKE, 32'h01);
      repeat (2) @(posedge clk);
      chk_bit("wake low", 1'b1, wake);
      test_done();
   end
endmodule
